/* File: rtl/arpp_core.v */
// Purpose: Result post-processing: averaging, oversampling, window monitor, offset/gain correction
// Assumes: Raw codes arrive on aclk from the conversion core, right aligned at the selected resolution
// Notes: Registers over AXI4-Lite; every output is driven by a flip-flop
//
// Behaviour
// [RL1] Averaging sums the selected number of samples and divides before publishing.
// [RL2] Sample count code 0..10 selects two to that power samples.
// [RL3] Divide by automatic shift plus adjust shift capped at four, total ten.
// [RL4] Software selects resolution code one before averaging two or more samples.
// [RL5] With averaging, result ready rises only after the full set completes.
// [RL6] Oversampling accumulates four to the n samples, shifts n, up to 16 bits.
// [RL7] Software pairs count and adjust codes for 13 to 16 bit results.
// [RL8] Window mode is a three-bit field; thresholds come from two registers.
// [RL9] Window compares signed in differential mode, unsigned otherwise.
// [RL10] Only threshold bits of the selected resolution take part; eight in 8-bit.
// [RL11] Differential 8-bit uses threshold bit seven as sign, ignoring bit eight.
// [RL12] Window match flag sets when a finished result meets the window condition.
// [RL13] With correction on, offset is subtracted from the code before storing.
// [RL14] Result is (code minus offset) times gain, only while correction enabled.
// [RL15] With correction, a single conversion result is delayed 13 more cycles.
// [RL16] Free running with correction delays only the first result.
// [RL17] Resolution offers 8, 10 and 12 bits, 12 bits after reset.
// [RL18] Ready request rises on complete result and clears on result read.
// [RL19] Reserved count codes act as one sample with no shift.
// [RL20] Gain is 1.11 fixed point; corrected result saturates to range.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
`include "arpp_consts.vh"
module arpp_core #(
  parameter CODE_W = 12
) (
  input wire aclk,
  input wire aresetn,
  input wire conv_valid,
  input wire [CODE_W-1:0] conv_code,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg result_ready_flag,
  output reg window_match_flag
);
  // Configuration and state
  reg [5:0] ctrl_q;
  reg [6:0] averaging_control_q;
  reg [2:0] window_mode_select_q;
  reg [15:0] window_lower_threshold_q;
  reg [15:0] window_upper_threshold_q;
  reg [11:0] offset_correction_value_q;
  reg [11:0] gain_correction_value_q;
  reg [15:0] result_q;
  reg [21:0] acc_q;
  reg [10:0] cnt_q;
  reg [15:0] pend_q;
  reg pend_vld_q;
  reg [3:0] delay_q;
  reg first_done_q;
  reg [5:0] aw_addr_q;
  reg aw_have_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_have_q;

  wire diff_mode = ctrl_q[`ARPP_CTRL_DIFF];
  wire correction_enable = ctrl_q[`ARPP_CTRL_CORR];
  wire free_run = ctrl_q[`ARPP_CTRL_FREE];
  wire [1:0] resolution_select = ctrl_q[`ARPP_CTRL_RES_HI:`ARPP_CTRL_RES_LO];
  wire [3:0] sample_count_select = averaging_control_q[`ARPP_AVG_CNT_HI:`ARPP_AVG_CNT_LO];
  wire [2:0] division_shift_adjust = averaging_control_q[`ARPP_AVG_ADJ_HI:`ARPP_AVG_ADJ_LO];

  // Accumulation control
  wire avg_on = (sample_count_select != 4'h0) && (sample_count_select <= `ARPP_CNT_MAX); // RL19
  wire [10:0] cnt_target = avg_on ? (11'h001 << sample_count_select) : 11'h001; // RL2
  wire [3:0] auto_shift = (sample_count_select > `ARPP_CNT_NOAUTO) ?
    (sample_count_select - `ARPP_CNT_NOAUTO) : 4'h0;
  wire [2:0] adj_capped = (division_shift_adjust > `ARPP_ADJ_MAX) ? `ARPP_ADJ_MAX : division_shift_adjust;
  wire [3:0] total_shift = avg_on ? (auto_shift + {1'b0, adj_capped}) : 4'h0; // RL3 RL6
  wire [21:0] acc_sum = acc_q + {{(22-CODE_W){1'b0}}, conv_code};
  wire [21:0] acc_div = acc_sum >> total_shift; // RL1
  wire set_done = conv_valid && (cnt_q + 11'h001 == cnt_target); // RL5
  wire [15:0] plain_val = avg_on ? acc_div[15:0] : {{(16-CODE_W){1'b0}}, conv_code};

  // Width of the published result
  reg [4:0] res_w;
  always @* begin
    if (avg_on) begin
      res_w = 5'd16; // RL6
    end else begin
      case (resolution_select) // RL17
        `ARPP_RES_8: res_w = 5'd8;
        `ARPP_RES_10: res_w = 5'd10;
        default: res_w = 5'd12;
      endcase
    end
  end

  // Keep the low w bits and extend from bit w-1 when signed
  function [16:0] arpp_ext;
    input [15:0] v;
    input [4:0] w;
    input sgn;
    integer i;
    begin
      for (i = 0; i < 17; i = i + 1) begin
        if (i < w)
          arpp_ext[i] = v[i];
        else
          arpp_ext[i] = sgn & v[w-1];
      end
    end
  endfunction

  // Offset and gain correction with saturation
  wire [16:0] plain_ext = arpp_ext(plain_val, res_w, diff_mode); // Signed codes in differential mode
  reg signed [17:0] corr_diff;
  reg signed [31:0] corr_prod;
  reg signed [31:0] corr_max;
  reg signed [31:0] corr_min;
  reg [15:0] corr_val;
  always @* begin
    corr_diff = $signed({plain_ext[16], plain_ext}) - $signed({{6{offset_correction_value_q[11]}},
      offset_correction_value_q}); // RL13
    corr_prod = (corr_diff * $signed({1'b0, gain_correction_value_q})) >>> `ARPP_GAIN_FRAC; // RL14 RL20
    corr_max = diff_mode ? ((32'sd1 <<< (res_w - 5'd1)) - 32'sd1) : ((32'sd1 <<< res_w) - 32'sd1);
    corr_min = diff_mode ? -(32'sd1 <<< (res_w - 5'd1)) : 32'sd0;
    if (!correction_enable)
      corr_val = plain_val; // RL14
    else if (corr_prod > corr_max)
      corr_val = corr_max[15:0]; // RL20
    else if (corr_prod < corr_min)
      corr_val = corr_min[15:0];
    else
      corr_val = corr_prod[15:0];
  end

  // Window comparison of the pending result
  wire [16:0] cmp_res = arpp_ext(pend_q, res_w, diff_mode); // RL9
  wire [16:0] cmp_low = arpp_ext(window_lower_threshold_q, res_w, diff_mode); // RL10 RL11
  wire [16:0] cmp_up = arpp_ext(window_upper_threshold_q, res_w, diff_mode); // RL10 RL11
  wire above = $signed(cmp_res) > $signed(cmp_low);
  wire below = $signed(cmp_res) < $signed(cmp_up);
  reg win_hit;
  always @* begin
    case (window_mode_select_q) // RL8
      `ARPP_WIN_ABOVE: win_hit = above;
      `ARPP_WIN_BELOW: win_hit = below;
      `ARPP_WIN_INSIDE: win_hit = above && below;
      `ARPP_WIN_OUTSIDE: win_hit = !(above && below);
      default: win_hit = 1'b0;
    endcase
  end

  // Bus decode
  wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] wval = w_data_q & wmask;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire rd_result = rd_go && (s_axi_araddr == `ARPP_OFS_RESULT);
  wire wr_status = wr_go && (aw_addr_q == `ARPP_OFS_STATUS);
  wire publish = pend_vld_q && (delay_q == 4'h0);
  reg wr_hit;
  always @* begin
    case (aw_addr_q)
      `ARPP_OFS_CTRL, `ARPP_OFS_AVG, `ARPP_OFS_WIN, `ARPP_OFS_WLOW, `ARPP_OFS_WUP,
      `ARPP_OFS_OFFS, `ARPP_OFS_GAIN, `ARPP_OFS_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Read mux
  reg [31:0] rd_val;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `ARPP_OFS_CTRL: rd_val = {26'h0, ctrl_q};
      `ARPP_OFS_AVG: rd_val = {25'h0, averaging_control_q};
      `ARPP_OFS_WIN: rd_val = {29'h0, window_mode_select_q};
      `ARPP_OFS_WLOW: rd_val = {16'h0, window_lower_threshold_q};
      `ARPP_OFS_WUP: rd_val = {16'h0, window_upper_threshold_q};
      `ARPP_OFS_OFFS: rd_val = {20'h0, offset_correction_value_q};
      `ARPP_OFS_GAIN: rd_val = {20'h0, gain_correction_value_q};
      `ARPP_OFS_RESULT: rd_val = {16'h0, result_q};
      `ARPP_OFS_STATUS: rd_val = {29'h0, pend_vld_q, window_match_flag, result_ready_flag};
      default: begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // AXI4-Lite handshakes; address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 6'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ARPP_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `ARPP_RESP_OK;
      s_axi_rdata <= 32'h0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !wr_go;
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !wr_go;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `ARPP_RESP_OK : `ARPP_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? `ARPP_RESP_OK : `ARPP_RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Register writes with byte strobes
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `ARPP_RST_CTRL; // RL17
      averaging_control_q <= `ARPP_RST_AVG;
      window_mode_select_q <= `ARPP_WIN_OFF;
      window_lower_threshold_q <= 16'h0;
      window_upper_threshold_q <= 16'h0;
      offset_correction_value_q <= 12'h0;
      gain_correction_value_q <= `ARPP_RST_GAIN;
    end else if (wr_go) begin
      case (aw_addr_q)
        `ARPP_OFS_CTRL: ctrl_q <= (ctrl_q & ~wmask[5:0]) | wval[5:0];
        `ARPP_OFS_AVG: averaging_control_q <= (averaging_control_q & ~wmask[6:0]) | wval[6:0];
        `ARPP_OFS_WIN: window_mode_select_q <= (window_mode_select_q & ~wmask[2:0]) | wval[2:0]; // RL8
        `ARPP_OFS_WLOW: window_lower_threshold_q <= (window_lower_threshold_q & ~wmask[15:0]) | wval[15:0];
        `ARPP_OFS_WUP: window_upper_threshold_q <= (window_upper_threshold_q & ~wmask[15:0]) | wval[15:0];
        `ARPP_OFS_OFFS: offset_correction_value_q <= (offset_correction_value_q & ~wmask[11:0]) | wval[11:0];
        `ARPP_OFS_GAIN: gain_correction_value_q <= (gain_correction_value_q & ~wmask[11:0]) | wval[11:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Accumulate samples and hand the finished value to the correction delay
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= 22'h0;
      cnt_q <= 11'h000;
      pend_q <= 16'h0;
      pend_vld_q <= 1'b0;
      delay_q <= 4'h0;
      first_done_q <= 1'b0;
    end else begin
      if (conv_valid) begin
        if (set_done) begin
          acc_q <= 22'h0; // RL1 RL5
          cnt_q <= 11'h000;
        end else begin
          acc_q <= acc_sum;
          cnt_q <= cnt_q + 11'h001;
        end
      end
      if (!free_run || !correction_enable)
        first_done_q <= 1'b0;
      else if (publish)
        first_done_q <= 1'b1; // RL16
      if (conv_valid && set_done) begin
        pend_q <= corr_val;
        pend_vld_q <= 1'b1;
        delay_q <= (correction_enable && !first_done_q) ? `ARPP_CORR_LAT : 4'h0; // RL15 RL16
      end else if (publish) begin
        pend_vld_q <= 1'b0;
      end else if (pend_vld_q) begin
        delay_q <= delay_q - 4'h1;
      end
    end
  end

  // Result register and sticky flags; a new event wins over a clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= 16'h0;
      result_ready_flag <= 1'b0;
      window_match_flag <= 1'b0;
    end else begin
      if (publish)
        result_q <= pend_q;
      result_ready_flag <= publish || (result_ready_flag && !rd_result); // RL5 RL18
      window_match_flag <= (publish && win_hit) ||
        (window_match_flag && !(wr_status && wval[`ARPP_ST_WIN])); // RL12
    end
  end

endmodule // arpp_core

/* File: rtl/arpp_consts.vh */
// Purpose: Constants for the converter result post-processing block
// Assumes: AXI4-Lite register window, 32-bit data, one register per aligned word
// Notes: Offsets are byte addresses
`ifndef ARPP_CONSTS_VH
`define ARPP_CONSTS_VH
// Register byte offsets
`define ARPP_OFS_CTRL 6'h00
`define ARPP_OFS_AVG 6'h04
`define ARPP_OFS_WIN 6'h08
`define ARPP_OFS_WLOW 6'h0c
`define ARPP_OFS_WUP 6'h10
`define ARPP_OFS_OFFS 6'h14
`define ARPP_OFS_GAIN 6'h18
`define ARPP_OFS_RESULT 6'h1c
`define ARPP_OFS_STATUS 6'h20
// Control register fields
`define ARPP_CTRL_DIFF 0
`define ARPP_CTRL_CORR 1
`define ARPP_CTRL_FREE 2
`define ARPP_CTRL_RES_LO 4
`define ARPP_CTRL_RES_HI 5
// Averaging register fields
`define ARPP_AVG_CNT_LO 0
`define ARPP_AVG_CNT_HI 3
`define ARPP_AVG_ADJ_LO 4
`define ARPP_AVG_ADJ_HI 6
// Status register fields
`define ARPP_ST_RDY 0
`define ARPP_ST_WIN 1
`define ARPP_ST_BUSY 2
// Resolution select codes
`define ARPP_RES_12 2'h0
`define ARPP_RES_16 2'h1
`define ARPP_RES_10 2'h2
`define ARPP_RES_8 2'h3
// Window modes
`define ARPP_WIN_OFF 3'h0
`define ARPP_WIN_ABOVE 3'h1
`define ARPP_WIN_BELOW 3'h2
`define ARPP_WIN_INSIDE 3'h3
`define ARPP_WIN_OUTSIDE 3'h4
// Sample count limits and shift caps
`define ARPP_CNT_MAX 4'ha
`define ARPP_CNT_NOAUTO 4'h4
`define ARPP_ADJ_MAX 3'h4
// Reset values
`define ARPP_RST_CTRL 6'h00
`define ARPP_RST_AVG 7'h00
`define ARPP_RST_GAIN 12'h800
// Gain is unsigned 1.11 fixed point, 12'h800 is unity
`define ARPP_GAIN_FRAC 11
// Correction latency in converter clock cycles
`define ARPP_CORR_LAT 4'hd
// Bus responses
`define ARPP_RESP_OK 2'h0
`define ARPP_RESP_ERR 2'h2
`endif

/* File: test/arpp_assertions.sv */
// Purpose: Port-level checks for the result post-processing block
// Assumes: One clock, synchronous active-low reset
// Notes: Attached to arpp_core by bind
`timescale 1ns/1ns
module arpp_chk (
  input wire aclk,
  input wire aresetn,
  input wire conv_valid,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire result_ready_flag,
  input wire window_match_flag
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read takes, and a read of the result word
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire res_rd = rd_take && (s_axi_araddr == 6'h1c);
  // Cycles since the last raw sample, saturating
  reg [4:0] idle_q;
  always @(posedge aclk) begin
    if (!aresetn || conv_valid) idle_q <= 5'h00;
    else if (idle_q != 5'h1f) idle_q <= idle_q + 5'h01;
  end
  a_ready_after_sample: assert property ($rose(result_ready_flag) |-> idle_q <= 5'h10)
    else $error("result ready with no recent sample");
  a_ready_clear_read: assert property ($fell(result_ready_flag) |-> $past(res_rd))
    else $error("result ready fell without a result read");
  a_win_with_result: assert property ($rose(window_match_flag) |-> result_ready_flag)
    else $error("window flag rose without a result");
  a_win_clear_write: assert property ($fell(window_match_flag) |-> $rose(s_axi_bvalid))
    else $error("window flag fell without a write");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read response dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered in two cycles");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_read_unmapped: assert property (rd_take && s_axi_araddr > 6'h20 |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  c_result: cover property ($rose(result_ready_flag));
  c_window: cover property ($rose(window_match_flag));
  c_unmapped: cover property (rd_take && s_axi_araddr > 6'h20);
endmodule // arpp_chk
bind arpp_core arpp_chk arpp_chk_inst (
  .aclk(aclk), .aresetn(aresetn), .conv_valid(conv_valid),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .result_ready_flag(result_ready_flag), .window_match_flag(window_match_flag)
);

/* File: test/arpp_conv_src.sv */
// Purpose: Conversion core model feeding raw samples
// Assumes: One-cycle sample strobe on aclk
// Notes: Code line shows the inverse of the last code when idle
`timescale 1ns/1ns
module arpp_conv_src #(
  parameter CODE_W = 12
) (
  output logic conv_valid,
  output logic [CODE_W-1:0] conv_code,
  input wire aclk
);
  initial begin
    conv_valid = 1'b0;
    conv_code = {CODE_W{1'b0}};
  end
  // Samples back to back when gap is zero, else idle cycles between
  task burst(input int n, input logic [CODE_W-1:0] code, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      conv_valid <= 1'b1;
      conv_code <= code;
      if (gap != 0) begin
        @(posedge aclk);
        conv_valid <= 1'b0;
        conv_code <= ~code;
        repeat (gap) @(posedge aclk);
      end
    end
    @(posedge aclk);
    conv_valid <= 1'b0;
    conv_code <= ~code;
  endtask
endmodule // arpp_conv_src

/* File: test/testbench.sv */
// Purpose: Self-checking bench for the result post-processing block
// Assumes: AXI4-Lite master tasks, conversion core model
// Notes: Scenarios cover averaging, window, correction and reset
`timescale 1ns/1ns
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic [5:0] s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  wire conv_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire result_ready_flag, window_match_flag;
  wire [11:0] conv_code;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int errors = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  // Free-running clock
  always #5 aclk = ~aclk;
  arpp_conv_src arpp_conv_src_inst (.aclk(aclk), .conv_valid(conv_valid), .conv_code(conv_code));
  arpp_core arpp_core_inst (
    .aclk(aclk), .aresetn(aresetn), .conv_valid(conv_valid), .conv_code(conv_code),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .result_ready_flag(result_ready_flag), .window_match_flag(window_match_flag)
  );
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One bus transfer, write when wr is high; response ready stands from the request on
  task ax(input logic wr, input logic [5:0] a, input logic [31:0] d);
    logic ad;
    logic wd;
    logic done;
    int t;
    ad = 1'b0;
    wd = !wr;
    done = 1'b0;
    t = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    while (!done && t < 40) begin
      @(posedge aclk);
      t++;
      ad = ad || (wr ? s_axi_awready : s_axi_arready);
      wd = wd || s_axi_wready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = wr ? s_axi_bresp : s_axi_rresp;
      s_axi_awvalid <= wr && !ad;
      s_axi_wvalid <= !wd;
      s_axi_arvalid <= !wr && !ad;
      s_axi_bready <= wr && !done;
      s_axi_rready <= !wr && !done;
    end
    if (!done) errors++;
  endtask
  // Edges until the result is ready
  task lat(output int k);
    k = 0;
    while (result_ready_flag !== 1'b1 && k < 40) begin
      @(posedge aclk);
      #1;
      k++;
    end
    if (k >= 40) errors++;
  endtask
  // Wait, read the result and see the ready flag clear
  task getres(input logic [31:0] exp);
    int k;
    lat(k);
    ax(1'b0, 6'h1c, 32'h0);
    chk(rd, exp);
    #1 chk(32'(result_ready_flag), 32'h0);
  endtask
  task t_reset;
    ax(1'b0, 6'h00, 32'h0);
    chk(rd, 32'h0);
    ax(1'b0, 6'h18, 32'h0);
    chk(rd, 32'h800);
    ax(1'b0, 6'h24, 32'h0);
    chk(32'(rsp), 32'h2);
    ax(1'b1, 6'h24, 32'h1);
    chk(32'(rsp), 32'h2);
  endtask
  // Every count code, reserved code and oversampling pairs
  task t_avg;
    logic [7:0] tbl [16];
    int n;
    int sh;
    logic [3:0] c;
    tbl = '{8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h45, 8'h46, 8'h47,
            8'h48, 8'h49, 8'h4a, 8'h3b, 8'h12, 8'h24, 8'h16, 8'h08};
    ax(1'b1, 6'h00, 32'h10);
    for (int i = 0; i < 16; i++) begin
      c = tbl[i][3:0];
      n = (c > 10) ? 1 : (1 << c);
      sh = (c > 10) ? 0 : ((c > 4) ? c - 4 : 0) + tbl[i][6:4];
      ax(1'b1, 6'h04, {24'h0, tbl[i]});
      if (n > 1) begin
        arpp_conv_src_inst.burst(n - 1, 12'habc, (i % 2) * 2);
        repeat (4) @(posedge aclk);
        #1 chk(32'(result_ready_flag), 32'h0);
      end
      arpp_conv_src_inst.burst(1, 12'habc, 0);
      getres((n * 32'habc) >> sh);
    end
  endtask
  // One window case
  task wc(input logic [31:0] ctl, md, lo, up, input logic [11:0] code, input logic [31:0] ex);
    ax(1'b1, 6'h00, ctl);
    ax(1'b1, 6'h04, 32'h0);
    ax(1'b1, 6'h08, md);
    ax(1'b1, 6'h0c, lo);
    ax(1'b1, 6'h10, up);
    ax(1'b1, 6'h20, 32'h2);
    arpp_conv_src_inst.burst(1, code, 0);
    getres({20'h0, code});
    chk(32'(window_match_flag), ex);
  endtask
  task t_win;
    for (int m = 0; m < 5; m++) begin
      wc(32'h0, m, 32'h100, 32'h200, 12'h180, (32'h0e >> m) & 32'h1);
      wc(32'h0, m, 32'h100, 32'h200, 12'h250, (32'h12 >> m) & 32'h1);
    end
    wc(32'h30, 32'h1, 32'h105, 32'h0, 12'h010, 32'h1);
    wc(32'h20, 32'h1, 32'h405, 32'h0, 12'h010, 32'h1);
    wc(32'h31, 32'h1, 32'h080, 32'h0, 12'h005, 32'h1);
    wc(32'h00, 32'h1, 32'hf00, 32'h0, 12'h005, 32'h0);
    wc(32'h01, 32'h1, 32'hf00, 32'h0, 12'h005, 32'h1);
  endtask
  // Offset, gain, saturation and correction delay
  task t_corr;
    int ka;
    int kb;
    ax(1'b1, 6'h00, 32'h0);
    ax(1'b1, 6'h14, 32'h10);
    ax(1'b1, 6'h18, 32'h400);
    arpp_conv_src_inst.burst(1, 12'h210, 0);
    lat(ka);
    ax(1'b0, 6'h1c, 32'h0);
    chk(rd, 32'h210);
    ax(1'b1, 6'h00, 32'h2);
    arpp_conv_src_inst.burst(1, 12'h210, 0);
    lat(kb);
    chk(32'(kb - ka), 32'd13);
    ax(1'b0, 6'h1c, 32'h0);
    chk(rd, 32'h100);
    arpp_conv_src_inst.burst(1, 12'h005, 0);
    getres(32'h0);
    ax(1'b1, 6'h18, 32'hfff);
    arpp_conv_src_inst.burst(1, 12'hfff, 0);
    getres(32'hfff);
    ax(1'b1, 6'h00, 32'h6);
    for (int j = 0; j < 2; j++) begin
      arpp_conv_src_inst.burst(1, 12'h210, 0);
      lat(kb);
      chk(32'(kb - ka), j ? 32'd0 : 32'd13);
      ax(1'b0, 6'h1c, 32'h0);
    end
  endtask
  // Main sequence with a second reset in mid-run
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_avg;
    t_win;
    t_corr;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    tally_and_finish;
  end
  // Watchdog
  initial begin
    #500000;
    errors++;
    tally_and_finish;
  end
endmodule // testbench
